// ### src/timer16_core.sv
// timer16_core: 16-bit counter with shared high-byte holding register on an 8-bit bus
// assumes: cpu bus synchronous to clk; prescaler taps and capture loads come from neighbours
//
// Functional notes
// - each 16-bit register moves over the 8-bit bus as two byte accesses
// - one 8-bit holding register serves all 16-bit registers
// - low byte write loads holding byte and written byte together (capture only while capture sets top)
// - low byte read of count or capture copies the register's upper byte into holding register
// - compare register reads return both bytes directly, holding register untouched
// - counter upper byte location accesses the holding register
// - three-bit clock select picks source; zero stops the counter
// - counter stays readable and writable with no timer clock
// - cpu counter write beats clear, increment and decrement
// - counter clears, increments or decrements on each timer tick per mode
// - four-bit waveform mode split across control registers a and b
// - top flags mode maximum; bottom flags zero
// - step is exactly one per tick in chosen direction; clear zeroes all
// - overflow flag set per mode, can request a cpu interrupt
// - bottom is 0x0000 and max is 0xFFFF
// - top is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare a or capture per mode
`timescale 1ns/1ps
`default_nettype none
module timer16_core (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // cpu byte bus
  input wire timer16_pkg::cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  // clock sources
  input wire logic [4:0] presc_tick,
  input wire logic ext_clk_pin,
  // capture load from the capture unit
  input wire logic capt_load,
  // links to the rest of the timer
  output timer16_pkg::cnt_stat_t cnt_stat,
  output logic [15:0] count_value,
  output logic [15:0] compare_a,
  output logic [15:0] compare_b,
  output logic [15:0] capture_reg,
  output logic overflow_flag,
  output logic ovf_irq
);

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;

  logic [7:0] hold_q;
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] cmpa_q;
  logic [15:0] cmpb_q;
  logic [15:0] capt_q;
  logic ovf_q;
  logic ovf_ie_q;
  dir_t dir_q;
  logic [3:0] wgm;
  logic [2:0] csel;
  logic [15:0] top_val;
  logic tick;
  logic tick_src;
  logic [4:0] tap_hit;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic ext_lvl_q;
  logic ext_rise;
  logic ext_fall;
  logic at_top;
  logic at_bottom;
  logic dual_slope;
  logic top_from_reg;
  logic wr_cnt_l;
  logic wr_ovf;
  logic wr_hi_byte;
  logic ovf_set;
  logic [7:0] rdata_d;

  wire logic rd = cpu_req.rd & clk_en;
  wire logic wr = cpu_req.wr & clk_en;

  // waveform mode field split across both control registers
  assign wgm = {ctrl_b_q[timer16_pkg::WGM_HI_POS +: 2],
                ctrl_a_q[timer16_pkg::WGM_LO_POS +: 2]};
  assign csel = ctrl_b_q[timer16_pkg::CS_POS +: 3];

  // external pin: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      ext_lvl_q <= 1'b0;
    end else if (clk_en) begin
      ext_s1_q <= ext_clk_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      if (ext_s2_q == ext_s3_q) begin
        ext_lvl_q <= ext_s3_q;
      end
    end
  end

  assign ext_rise = (ext_s2_q == ext_s3_q) & ext_s3_q & ~ext_lvl_q;
  assign ext_fall = (ext_s2_q == ext_s3_q) & ~ext_s3_q & ext_lvl_q;

  // one decode per prescaler tap: select codes 1 to 5 pick taps 0 to 4
  for (genvar i = 0; i < $bits(presc_tick); i++) begin : g_tap
    assign tap_hit[i] = presc_tick[i] & (csel == 3'(i + 1));
  end

  // clock select to single-cycle tick
  always_comb begin
    unique case (csel)
      timer16_pkg::CS_STOP: tick_src = 1'b0;
      timer16_pkg::CS_EXT_FALL: tick_src = ext_fall;
      timer16_pkg::CS_EXT_RISE: tick_src = ext_rise;
      default: tick_src = |tap_hit;
    endcase
  end

  // a frozen core must not report a tick it will not count
  assign tick = tick_src & clk_en;

  // top per mode
  always_comb begin
    top_from_reg = 1'b0;
    unique case (wgm)
      timer16_pkg::WGM_PC8, timer16_pkg::WGM_FAST8: top_val = timer16_pkg::TOP_8BIT;
      timer16_pkg::WGM_PC9, timer16_pkg::WGM_FAST9: top_val = timer16_pkg::TOP_9BIT;
      timer16_pkg::WGM_PC10, timer16_pkg::WGM_FAST10: top_val = timer16_pkg::TOP_10BIT;
      timer16_pkg::WGM_CTC_A, timer16_pkg::WGM_PFC_A, timer16_pkg::WGM_PC_A,
      timer16_pkg::WGM_FAST_A: top_val = cmpa_q;
      timer16_pkg::WGM_PFC_I, timer16_pkg::WGM_PC_I, timer16_pkg::WGM_CTC_I,
      timer16_pkg::WGM_FAST_I: begin
        top_val = capt_q;
        top_from_reg = 1'b1;
      end
      default: top_val = timer16_pkg::MAX_VAL;
    endcase
  end

  assign dual_slope = (wgm inside {timer16_pkg::WGM_PC8, timer16_pkg::WGM_PC9,
                       timer16_pkg::WGM_PC10, timer16_pkg::WGM_PFC_I, timer16_pkg::WGM_PFC_A,
                       timer16_pkg::WGM_PC_I, timer16_pkg::WGM_PC_A});
  assign at_top = (cnt_q == top_val);
  assign at_bottom = (cnt_q == timer16_pkg::BOTTOM_VAL);
  assign wr_cnt_l = wr & (cpu_req.addr == timer16_pkg::ADDR_CNT_L);

  // next count: cpu write first, then clear or one step
  always_comb begin
    cnt_d = cnt_q;
    if (wr_cnt_l) begin
      cnt_d = {hold_q, cpu_req.wdata};
    end else if (tick) begin
      if (!dual_slope && at_top) begin
        cnt_d = timer16_pkg::BOTTOM_VAL;
      end else if (dual_slope && (at_top ? 1'b1 : dir_q == DIR_DOWN) && !at_bottom) begin
        cnt_d = cnt_q - timer16_pkg::ONE16;
      end else begin
        cnt_d = cnt_q + timer16_pkg::ONE16;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= timer16_pkg::BOTTOM_VAL;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  // direction for dual-slope modes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dir_q <= DIR_UP;
    end else if (clk_en && tick) begin
      if (!dual_slope || at_bottom) begin
        dir_q <= DIR_UP;
      end else if (at_top) begin
        dir_q <= DIR_DOWN;
      end
    end
  end

  // overflow flag: set wins over software clear (write one)
  assign wr_ovf = wr & (cpu_req.addr == timer16_pkg::ADDR_FLAGS);
  // dual-slope modes overflow at bottom, single-slope modes at top
  assign ovf_set = tick & (dual_slope ? at_bottom : at_top);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ovf_q <= 1'b0;
      ovf_ie_q <= 1'b0;
    end else if (clk_en) begin
      if (ovf_set) begin
        ovf_q <= 1'b1;
      end else if (wr_ovf && cpu_req.wdata[timer16_pkg::FLAG_OVF_POS]) begin
        ovf_q <= 1'b0;
      end
      if (wr_ovf) begin
        ovf_ie_q <= cpu_req.wdata[timer16_pkg::FLAG_IE_POS];
      end
    end
  end

  // control and 16-bit register writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_a_q <= timer16_pkg::ZERO8;
      ctrl_b_q <= timer16_pkg::ZERO8;
      cmpa_q <= timer16_pkg::BOTTOM_VAL;
      cmpb_q <= timer16_pkg::BOTTOM_VAL;
      capt_q <= timer16_pkg::BOTTOM_VAL;
    end else if (clk_en) begin
      if (wr) begin
        unique case (cpu_req.addr)
          timer16_pkg::ADDR_CTRL_A: ctrl_a_q <= cpu_req.wdata;
          timer16_pkg::ADDR_CTRL_B: ctrl_b_q <= cpu_req.wdata;
          timer16_pkg::ADDR_CMPA_L: cmpa_q <= {hold_q, cpu_req.wdata};
          timer16_pkg::ADDR_CMPB_L: cmpb_q <= {hold_q, cpu_req.wdata};
          // capture register takes cpu writes only while it sets top
          timer16_pkg::ADDR_CAPT_L: begin
            if (top_from_reg) begin
              capt_q <= {hold_q, cpu_req.wdata};
            end
          end
          default: ;
        endcase
      end
      // no capture while the capture register sets top
      if (capt_load && !top_from_reg) begin
        capt_q <= cnt_q;
      end
    end
  end

  // shared holding byte: all upper-byte writes, low-byte reads of count and capture
  assign wr_hi_byte = wr & (cpu_req.addr inside {timer16_pkg::ADDR_CNT_H,
                                                 timer16_pkg::ADDR_CMPA_H,
                                                 timer16_pkg::ADDR_CMPB_H,
                                                 timer16_pkg::ADDR_CAPT_H});
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_q <= timer16_pkg::ZERO8;
    end else if (clk_en) begin
      if (wr_hi_byte) begin
        hold_q <= cpu_req.wdata;
      end else if (rd && cpu_req.addr == timer16_pkg::ADDR_CNT_L) begin
        hold_q <= cnt_q[15:8];
      end else if (rd && cpu_req.addr == timer16_pkg::ADDR_CAPT_L) begin
        hold_q <= capt_q[15:8];
      end
    end
  end

  // read mux; host reads low byte then high byte for count and capture
  always_comb begin
    unique case (cpu_req.addr)
      timer16_pkg::ADDR_CTRL_A: rdata_d = ctrl_a_q;
      timer16_pkg::ADDR_CTRL_B: rdata_d = ctrl_b_q;
      timer16_pkg::ADDR_CNT_L: rdata_d = cnt_q[7:0];
      timer16_pkg::ADDR_CNT_H: rdata_d = hold_q;
      timer16_pkg::ADDR_CMPA_L: rdata_d = cmpa_q[7:0];
      timer16_pkg::ADDR_CMPA_H: rdata_d = cmpa_q[15:8];
      timer16_pkg::ADDR_CMPB_L: rdata_d = cmpb_q[7:0];
      timer16_pkg::ADDR_CMPB_H: rdata_d = cmpb_q[15:8];
      timer16_pkg::ADDR_CAPT_L: rdata_d = capt_q[7:0];
      timer16_pkg::ADDR_CAPT_H: rdata_d = hold_q;
      timer16_pkg::ADDR_FLAGS: rdata_d = {6'h00, ovf_ie_q, ovf_q};
      default: rdata_d = timer16_pkg::ZERO8;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_rdata <= timer16_pkg::ZERO8;
    end else if (clk_en && rd) begin
      cpu_rdata <= rdata_d;
    end
  end

  // outputs
  assign count_value = cnt_q;
  assign compare_a = cmpa_q;
  assign compare_b = cmpb_q;
  assign capture_reg = capt_q;
  assign overflow_flag = ovf_q;
  assign ovf_irq = ovf_q & ovf_ie_q;
  assign cnt_stat = '{top: at_top,
                      bottom: at_bottom,
                      max: (cnt_q == timer16_pkg::MAX_VAL),
                      dir_down: (dir_q == DIR_DOWN),
                      tick: tick};

endmodule : timer16_core
`default_nettype wire

// ### src/timer16_pkg.sv
// timer16_pkg: constants and carrier types for the 16-bit timer counter core
// assumes: 8-bit cpu i/o bus, single system clock domain
package timer16_pkg;

  // byte locations on the 8-bit i/o bus (choice of this block)
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_CNT_L = 4'h2;
  localparam logic [3:0] ADDR_CNT_H = 4'h3;
  localparam logic [3:0] ADDR_CMPA_L = 4'h4;
  localparam logic [3:0] ADDR_CMPA_H = 4'h5;
  localparam logic [3:0] ADDR_CMPB_L = 4'h6;
  localparam logic [3:0] ADDR_CMPB_H = 4'h7;
  localparam logic [3:0] ADDR_CAPT_L = 4'h8;
  localparam logic [3:0] ADDR_CAPT_H = 4'h9;
  localparam logic [3:0] ADDR_FLAGS = 4'hA;

  // count limits
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [15:0] MAX_VAL = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0] ZERO8 = 8'h00;

  // field positions
  localparam int WGM_LO_POS = 0;   // control_reg_a bits 1:0 -> mode bits 1:0
  localparam int WGM_HI_POS = 3;   // control_reg_b bits 4:3 -> mode bits 3:2
  localparam int CS_POS = 0;       // control_reg_b bits 2:0
  localparam int FLAG_OVF_POS = 0; // overflow flag in flag register
  localparam int FLAG_IE_POS = 1;  // overflow request enable in flag register
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // waveform modes
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PC8 = 4'h1;
  localparam logic [3:0] WGM_PC9 = 4'h2;
  localparam logic [3:0] WGM_PC10 = 4'h3;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_FAST8 = 4'h5;
  localparam logic [3:0] WGM_FAST9 = 4'h6;
  localparam logic [3:0] WGM_FAST10 = 4'h7;
  localparam logic [3:0] WGM_PFC_I = 4'h8;
  localparam logic [3:0] WGM_PFC_A = 4'h9;
  localparam logic [3:0] WGM_PC_I = 4'hA;
  localparam logic [3:0] WGM_PC_A = 4'hB;
  localparam logic [3:0] WGM_CTC_I = 4'hC;
  localparam logic [3:0] WGM_FAST_I = 4'hE;
  localparam logic [3:0] WGM_FAST_A = 4'hF;

  // cpu byte access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } cpu_req_t;

  // status toward the rest of the timer
  typedef struct packed {
    logic top;
    logic bottom;
    logic max;
    logic dir_down;
    logic tick;
  } cnt_stat_t;

endpackage : timer16_pkg

// ### tb/cpu_bus_model.sv
// cpu_bus_model: byte-wide cpu master for the timer core
// assumes: shares clk with the core, one access at a time
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  // clock
  input wire logic clk,
  // byte bus
  output var timer16_pkg::cpu_req_t cpu_req,
  input wire logic [7:0] cpu_rdata
);
  initial cpu_req = '0;
  // one byte per access, an idle edge between accesses
  task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk) cpu_req <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clk) cpu_req <= '0;
    @(negedge clk) q = cpu_rdata;
  endtask : acc
  // upper byte first, nothing between the two bytes
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b0, lo + 4'h1, v[15:8], q);
    acc(1'b0, lo, v[7:0], q);
  endtask : wr16
  // lower byte first, nothing between the two bytes
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    acc(1'b1, lo, 8'h00, v[7:0]);
    acc(1'b1, lo + 4'h1, 8'h00, v[15:8]);
  endtask : rd16
endmodule : cpu_bus_model
`default_nettype wire

// ### tb/test_timer16_byte_access_counter.sv
// test_timer16_byte_access_counter: directed bench for the timer counter core
// assumes: cpu_bus_model drives the byte bus, prescaler taps come from here
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_timer16_byte_access_counter;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] presc_tick = 5'h00;
  logic ext_clk_pin = 1'b0;
  logic capt_load = 1'b0;
  logic [7:0] cpu_rdata;
  logic [7:0] q;
  logic [15:0] v;
  timer16_pkg::cpu_req_t cpu_req;
  timer16_pkg::cnt_stat_t cnt_stat;
  logic [15:0] count_value, compare_a, compare_b, capture_reg;
  logic overflow_flag, ovf_irq;
  int fail_count = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  timer16_core timer16_core_inst (.clk(clk), .reset(reset), .clk_en(1'b1), .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata), .presc_tick(presc_tick), .ext_clk_pin(ext_clk_pin),
    .capt_load(capt_load),
    .cnt_stat(cnt_stat), .count_value(count_value), .compare_a(compare_a),
    .compare_b(compare_b), .capture_reg(capture_reg), .overflow_flag(overflow_flag),
    .ovf_irq(ovf_irq));
  cpu_bus_model cpu_bus_model_inst (.clk(clk), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata));
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cpu_bus_model_inst.acc(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    cpu_bus_model_inst.acc(1'b1, a, 8'h00, q);
  endtask : rd
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk) presc_tick <= 5'h01;
      @(posedge clk) presc_tick <= 5'h00;
    end
    @(negedge clk);
  endtask : ticks
  task automatic pin(input logic b);
    @(posedge clk) ext_clk_pin <= b;
    repeat (5) @(posedge clk);
  endtask : pin
  task automatic wrap_up;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    `CHK("count reset", 16'h0000, count_value)
    `CHK("bottom", 1'b1, cnt_stat.bottom)
    cpu_bus_model_inst.wr16(timer16_pkg::ADDR_CNT_L, 16'h01FF);
    `CHK("count write", 16'h01FF, count_value)
    wr(timer16_pkg::ADDR_CNT_H, 8'hAB);
    `CHK("high alone", 16'h01FF, count_value)
    cpu_bus_model_inst.rd16(timer16_pkg::ADDR_CNT_L, v);
    `CHK("count read", 16'h01FF, v)
    wr(timer16_pkg::ADDR_CMPA_H, 8'h12);
    wr(timer16_pkg::ADDR_CMPA_L, 8'h34);
    wr(timer16_pkg::ADDR_CMPB_L, 8'h56);
    `CHK("compare a", 16'h1234, compare_a)
    `CHK("compare b", 16'h1256, compare_b)
    rd(timer16_pkg::ADDR_CNT_L);
    rd(timer16_pkg::ADDR_CMPB_H);
    `CHK("cmp b high", 8'h12, q)
    rd(timer16_pkg::ADDR_CMPA_L);
    `CHK("cmp a low", 8'h34, q)
    rd(timer16_pkg::ADDR_CMPA_H);
    `CHK("cmp a high", 8'h12, q)
    rd(timer16_pkg::ADDR_CNT_H);
    `CHK("held byte", 8'h01, q)
    rd(4'hB);
    `CHK("unmapped", 8'h00, q)
    ticks(3);
    `CHK("stopped", 16'h01FF, count_value)
    wr(timer16_pkg::ADDR_CTRL_B, 8'h01);
    ticks(3);
    `CHK("three ticks", 16'h0202, count_value)
    wr(timer16_pkg::ADDR_CNT_H, 8'h00);
    fork
      wr(timer16_pkg::ADDR_CNT_L, 8'h10);
      begin
        @(posedge clk) presc_tick <= 5'h01;
        @(posedge clk) presc_tick <= 5'h00;
      end
    join
    `CHK("write wins", 16'h0010, count_value)
    cpu_bus_model_inst.wr16(timer16_pkg::ADDR_CNT_L, 16'hFFFF);
    `CHK("top at max", 1'b1, cnt_stat.top)
    `CHK("max", 1'b1, cnt_stat.max)
    wr(timer16_pkg::ADDR_FLAGS, 8'h02);
    ticks(1);
    `CHK("wrap", 16'h0000, count_value)
    `CHK("overflow", 1'b1, overflow_flag)
    `CHK("ovf request", 1'b1, ovf_irq)
    wr(timer16_pkg::ADDR_FLAGS, 8'h03);
    `CHK("ovf cleared", 1'b0, overflow_flag)
    wr(timer16_pkg::ADDR_CTRL_A, 8'h01);
    cpu_bus_model_inst.wr16(timer16_pkg::ADDR_CNT_L, 16'h00FE);
    ticks(1);
    `CHK("top 8 bit", 1'b1, cnt_stat.top)
    ticks(1);
    `CHK("dual slope", 16'h00FE, count_value)
    `CHK("down", 1'b1, cnt_stat.dir_down)
    @(posedge clk) capt_load <= 1'b1;
    @(posedge clk) capt_load <= 1'b0;
    cpu_bus_model_inst.rd16(timer16_pkg::ADDR_CAPT_L, v);
    `CHK("capture read", 16'h00FE, v)
    cpu_bus_model_inst.wr16(timer16_pkg::ADDR_CAPT_L, 16'h1234);
    `CHK("capture kept", 16'h00FE, capture_reg)
    wr(timer16_pkg::ADDR_CTRL_A, 8'h00);
    wr(timer16_pkg::ADDR_CTRL_B, 8'h19);
    cpu_bus_model_inst.wr16(timer16_pkg::ADDR_CAPT_L, 16'h0005);
    `CHK("capture top", 16'h0005, capture_reg)
    cpu_bus_model_inst.wr16(timer16_pkg::ADDR_CNT_L, 16'h0004);
    ticks(1);
    `CHK("top capture", 1'b1, cnt_stat.top)
    ticks(1);
    `CHK("clear at top", 16'h0000, count_value)
    wr(timer16_pkg::ADDR_CTRL_B, 8'h07);
    pin(1'b1);
    pin(1'b0);
    `CHK("ext rise", 16'h0001, count_value)
    wr(timer16_pkg::ADDR_CTRL_B, 8'h06);
    pin(1'b1);
    pin(1'b0);
    `CHK("ext fall", 16'h0002, count_value)
    wrap_up();
  end
endmodule : test_timer16_byte_access_counter
bind timer16_core timer16_core_asserts timer16_core_asserts_inst (.clk(clk), .reset(reset),
  .clk_en(clk_en), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .cnt_stat(cnt_stat),
  .count_value(count_value), .compare_a(compare_a), .overflow_flag(overflow_flag),
  .ovf_irq(ovf_irq));
`default_nettype wire

// ### tb/timer16_core_asserts.sv
// timer16_core_asserts: port-level checks on the timer counter core
// assumes: bound to timer16_core, one clock domain
`timescale 1ns/1ps
`default_nettype none
module timer16_core_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // cpu byte bus
  input wire timer16_pkg::cpu_req_t cpu_req,
  input wire logic [7:0] cpu_rdata,
  // counter status
  input wire timer16_pkg::cnt_stat_t cnt_stat,
  input wire logic [15:0] count_value,
  input wire logic [15:0] compare_a,
  input wire logic overflow_flag,
  input wire logic ovf_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire rd_only = clk_en && cpu_req.rd && !cpu_req.wr;
  wire lo_wr = clk_en && cpu_req.wr && cpu_req.addr == timer16_pkg::ADDR_CNT_L;
  wire lo_rd = rd_only && cpu_req.addr == timer16_pkg::ADDR_CNT_L;
  wire hi_rd = rd_only && cpu_req.addr == timer16_pkg::ADDR_CNT_H;
  wire idle = !cpu_req.rd && !cpu_req.wr;
  chk_bottom_flag: assert property (cnt_stat.bottom == (count_value == 16'h0000))
    else $error("bottom flag disagrees with count");
  chk_max_flag: assert property (cnt_stat.max == (count_value == 16'hFFFF))
    else $error("max flag disagrees with count");
  chk_write_wins: assert property (lo_wr |=> count_value[7:0] == $past(cpu_req.wdata))
    else $error("counter low byte write lost");
  chk_step_one: assert property (cnt_stat.tick && !lo_wr |=>
    (count_value - $past(count_value)) inside {16'h0001, 16'hFFFF} || count_value == 16'h0000)
    else $error("counter moved by other than one");
  chk_hold_still: assert property (!cnt_stat.tick && !lo_wr |=> $stable(count_value))
    else $error("counter moved without tick or write");
  chk_cmp_direct: assert property (rd_only && cpu_req.addr == timer16_pkg::ADDR_CMPA_H
    |=> cpu_rdata == $past(compare_a[15:8]))
    else $error("compare high read not direct");
  chk_high_via_hold: assert property (lo_rd ##1 idle ##1 hi_rd
    |=> cpu_rdata == $past(count_value[15:8], 3))
    else $error("counter high read not from held byte");
  chk_irq_gate: assert property (ovf_irq |-> overflow_flag)
    else $error("overflow request without flag");
  chk_ovf_cause: assert property ($rose(overflow_flag) |-> $past(cnt_stat.tick))
    else $error("overflow flag set without tick");
endmodule : timer16_core_asserts
`default_nettype wire
